// File: common/completion_event_bit_pkg.sv
// Package: register map, field positions and states of the completion event unit
// Overview of operation
// RULE1 - Enabled completion plus debug mode raises event
// RULE2 - Suppressed faulting instruction raises no event
// RULE3 - System call counts as executed, raises event
// RULE4 - Event sets status flag, saves next address
// RULE5 - No debug mode means event ignored
// RULE6 - Round exception sets status and imprecise flags
// RULE7 - Round interrupt first, saves following address
// RULE8 - Debug address then points at round handler
// RULE9 - Round behaviour under internal or external mode
// RULE10 - Instruction setting debug enable raises nothing
// RULE11 - Instruction setting completion enable raises nothing
// RULE12 - Status flag sticky until software clears
package cmpl_pkg;
   // Register byte offsets
   localparam logic [4:0] OFS_CTRL   = 5'h00;
   localparam logic [4:0] OFS_STATUS = 5'h04;
   localparam logic [4:0] OFS_MASK   = 5'h08;
   localparam logic [4:0] OFS_DSRA   = 5'h0c;
   localparam logic [4:0] OFS_SRA    = 5'h10;
   // Control fields of debug_control_0
   localparam int CTL_CMP = 0;  // completion_event_bit
   localparam int CTL_EXT = 1;  // external_debug_mode
   localparam int CTL_INT = 2;  // internal_debug_mode
   localparam int CTL_W   = 3;
   // Status and mask fields of debug_status_reg
   localparam int ST_CMP = 0;   // completion flag
   localparam int ST_IMP = 1;   // imprecise_event_flag
   localparam int ST_W   = 2;
   // Reset values
   localparam logic [CTL_W-1:0] CTRL_RST = 3'h0;
   localparam logic [ST_W-1:0]  ST_RST   = 2'h0;
   // Round exception sequencing
   typedef enum logic [0:0] {S_IDLE, S_ROUND} seq_e;
endpackage : cmpl_pkg

// File: logic/completion_event_bit_event.sv
// Instruction completion debug event detector with Wishbone register file
module cmpl_event
   import cmpl_pkg::*;
#(
   parameter int AW = 32  // Instruction address width
)(
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // Wishbone classic slave
   input  wire logic          cyc_i,
   input  wire logic          stb_i,
   input  wire logic          we_i,
   input  wire logic [4:0]    adr_i,
   input  wire logic [3:0]    sel_i,
   input  wire logic [31:0]   dat_i,
   output logic [31:0]        dat_o,
   output logic               ack_o,
   // Core completion interface
   input  wire logic          done_i,        // Instruction finished this cycle
   input  wire logic          suppressed_i,  // Raised another enabled exception
   input  wire logic          syscall_i,     // Instruction is a system call
   input  wire logic          dbg_en_i,      // internal_debug_enable at execution
   input  wire logic          sets_dbg_en_i, // Instruction sets internal_debug_enable
   input  wire logic          sets_cmp_i,    // Instruction sets completion_event_bit
   input  wire logic          round_exc_i,   // Float round exception on this one
   input  wire logic [AW-1:0] next_addr_i,   // Address of next instruction
   input  wire logic [AW-1:0] round_vec_i,   // Round exception handler entry
   // Interrupt side
   output logic               round_take_o,  // Round interrupt taken pulse
   output logic               debug_take_o,  // Debug interrupt taken pulse
   output logic [AW-1:0]      sra_o,         // save_restore_addr
   output logic [AW-1:0]      dsra_o,        // debug_save_restore_addr
   output logic               irq_o          // Unmasked status level
);
   import cmpl_pkg::*;

   // Whole module state
   typedef struct packed {
      logic [CTL_W-1:0] ctrl;       // debug_control_0 bits
      logic [ST_W-1:0]  status;     // debug_status_reg bits
      logic [ST_W-1:0]  mask;       // Interrupt mask
      logic [AW-1:0]    dsra;       // debug_save_restore_addr
      logic [AW-1:0]    sra;        // save_restore_addr
      logic [31:0]      rdata;      // Read data
      logic             ack;        // Bus acknowledge
      seq_e             seq;        // Round sequencing
      logic             round_take; // Round interrupt pulse
      logic             debug_take; // Debug interrupt pulse
   } state_s;

   state_s st_reg;   // Registered state
   state_s st_next;  // Next state

   // Decoded event terms
   logic dbg_on;      // Either debug mode active
   logic counts;      // Instruction counts as executed
   logic excluded;    // Instruction alters the enabling bits
   logic cmp_evt;     // Precise completion event
   logic round_evt;   // Imprecise round case
   logic wr_en;       // Write lands this edge
   logic [ST_W-1:0] set_bits;  // Hardware sets this cycle

   // Zero-extend a narrow field to a bus word
   function automatic logic [31:0] ext3(input logic [CTL_W-1:0] v);
      ext3 = {{(32-CTL_W){1'b0}}, v};
   endfunction : ext3

   function automatic logic [31:0] ext2(input logic [ST_W-1:0] v);
      ext2 = {{(32-ST_W){1'b0}}, v};
   endfunction : ext2

   // Event qualification
   always_comb
   begin
      // Debug mode is internal enable or external mode
      dbg_on   = dbg_en_i | st_reg.ctrl[CTL_EXT];                // [RULE1] [RULE5]
      // Syscall executes even though it raises its own interrupt
      counts   = done_i & (~suppressed_i | syscall_i);           // [RULE2] [RULE3]
      // Instructions that turn the event on never report themselves
      excluded = (sets_dbg_en_i & st_reg.ctrl[CTL_CMP])          // [RULE10]
               | (sets_cmp_i & dbg_on);                          // [RULE11]
      // Round case needs internal or external debug mode; decoded first
      // because the precise term is masked by it
      round_evt = done_i & round_exc_i & st_reg.ctrl[CTL_CMP] & ~excluded
                & (st_reg.ctrl[CTL_INT] | st_reg.ctrl[CTL_EXT]); // [RULE9]
      cmp_evt  = st_reg.ctrl[CTL_CMP] & dbg_on & counts & ~excluded    // [RULE1]
               & ~round_evt;
      set_bits = '0;
      if (cmp_evt)
      begin
         set_bits[ST_CMP] = 1'b1;
      end
      if (round_evt)
      begin
         set_bits[ST_CMP] = 1'b1;                                // [RULE6]
         set_bits[ST_IMP] = 1'b1;
      end
      wr_en = cyc_i & stb_i & we_i & st_reg.ack & sel_i[0];
   end

   // Next state
   always_comb
   begin
      st_next = st_reg;
      st_next.round_take = 1'b0;
      st_next.debug_take = 1'b0;
      // Bus: ack one cycle after request, dropped next cycle
      st_next.ack = cyc_i & stb_i & ~st_reg.ack;
      st_next.rdata = '0;
      if (cyc_i & stb_i & ~st_reg.ack & ~we_i)
      begin
         case (adr_i)
            OFS_CTRL:   st_next.rdata = ext3(st_reg.ctrl);
            OFS_STATUS: st_next.rdata = ext2(st_reg.status);
            OFS_MASK:   st_next.rdata = ext2(st_reg.mask);
            OFS_DSRA:   st_next.rdata = 32'(st_reg.dsra);
            OFS_SRA:    st_next.rdata = 32'(st_reg.sra);
            default:    st_next.rdata = '0;  // Unmapped reads zero
         endcase
      end
      // Register writes at the acknowledging edge
      if (wr_en)
      begin
         case (adr_i)
            OFS_CTRL:   st_next.ctrl = dat_i[CTL_W-1:0];
            // Write one to clear; a set in the same cycle survives below
            OFS_STATUS: st_next.status = st_reg.status & ~dat_i[ST_W-1:0];
            OFS_MASK:   st_next.mask = dat_i[ST_W-1:0];
            default:    st_next.ctrl = st_next.ctrl;  // Read-only or unmapped
         endcase
      end
      // Instruction that sets the enable bit updates control
      if (sets_cmp_i)
      begin
         st_next.ctrl[CTL_CMP] = 1'b1;
      end
      // Sticky flags: hardware set wins over software clear
      st_next.status = st_next.status | set_bits;                // [RULE12]
      case (st_reg.seq)
         S_IDLE:
         begin
            if (round_evt)
            begin
               // Round interrupt first so it is not lost
               st_next.round_take = 1'b1;                        // [RULE7]
               st_next.sra = next_addr_i;
               st_next.dsra = round_vec_i;                       // [RULE8]
               st_next.seq = S_ROUND;
            end
            else if (cmp_evt)
            begin
               st_next.dsra = next_addr_i;                       // [RULE4]
               st_next.debug_take = 1'b1;
            end
         end
         S_ROUND:
         begin
            // Debug interrupt follows, aimed at the round handler
            st_next.debug_take = 1'b1;                           // [RULE8]
            st_next.seq = S_IDLE;
         end
         default:
         begin
            st_next.seq = S_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg <= '{ctrl: CTRL_RST, status: ST_RST, mask: ST_RST, dsra: '0, sra: '0,
                     rdata: '0, ack: 1'b0, seq: S_IDLE, round_take: 1'b0, debug_take: 1'b0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs
   assign dat_o        = st_reg.rdata;
   assign ack_o        = st_reg.ack;
   assign round_take_o = st_reg.round_take;
   assign debug_take_o = st_reg.debug_take;
   assign sra_o        = st_reg.sra;
   assign dsra_o       = st_reg.dsra;
   assign irq_o        = |(st_reg.status & st_reg.mask);

   // Checks
   // Eligible instruction records flag, take and next address
   property p_event;
      @(posedge clk_i) disable iff (rst_i)
      (done_i & ~suppressed_i & ~round_exc_i & st_reg.ctrl[CTL_CMP] & dbg_en_i & ~sets_dbg_en_i & ~sets_cmp_i)
      |=> st_reg.status[ST_CMP] && debug_take_o && dsra_o == $past(next_addr_i);
   endproperty
   a_event: assert property (p_event) else $error("completion event not recorded"); // [RULE1] [RULE4]

   // Faulting instruction that is not a syscall stays silent
   property p_suppress;
      @(posedge clk_i) disable iff (rst_i)
      (st_reg.seq == S_IDLE & done_i & suppressed_i & ~syscall_i & ~round_exc_i) |=> !debug_take_o;
   endproperty
   a_suppress: assert property (p_suppress) else $error("suppressed instruction raised event"); // [RULE2]

   // Syscall still reports its completion
   property p_syscall;
      @(posedge clk_i) disable iff (rst_i)
      (done_i & suppressed_i & syscall_i & ~round_exc_i & st_reg.ctrl[CTL_CMP] & dbg_on & ~excluded)
      |=> debug_take_o;
   endproperty
   a_syscall: assert property (p_syscall) else $error("system call raised no event"); // [RULE3]

   // Neither debug mode on: nothing taken
   property p_off;
      @(posedge clk_i) disable iff (rst_i)
      (st_reg.seq == S_IDLE & ~dbg_en_i & ~st_reg.ctrl[CTL_EXT] & ~round_exc_i) |=> !debug_take_o;
   endproperty
   a_off: assert property (p_off) else $error("event without debug mode"); // [RULE5]

   // Round interrupt first, debug interrupt one cycle later
   property p_round;
      @(posedge clk_i) disable iff (rst_i)
      round_evt |=> round_take_o && !debug_take_o && st_reg.status == 2'h3
                    && sra_o == $past(next_addr_i) ##1 debug_take_o && !round_take_o;
   endproperty
   a_round: assert property (p_round) else $error("round sequence wrong"); // [RULE6] [RULE7]

   // Handler entry captured at the event edge, held over the debug take
   property p_round_vec;
      @(posedge clk_i) disable iff (rst_i)
      round_evt |=> dsra_o == $past(round_vec_i) ##1 dsra_o == $past(round_vec_i, 2);
   endproperty
   a_round_vec: assert property (p_round_vec) else $error("debug address not round handler"); // [RULE8]

   // External mode alone also enables the round case
   property p_round_ext;
      @(posedge clk_i) disable iff (rst_i)
      (st_reg.seq == S_IDLE & done_i & round_exc_i & st_reg.ctrl[CTL_CMP] & st_reg.ctrl[CTL_EXT] & ~excluded)
      |=> round_take_o;
   endproperty
   a_round_ext: assert property (p_round_ext) else $error("round case missed in external mode"); // [RULE9]

   // Turning on the debug enable is not itself reported
   property p_set_dbg_en;
      @(posedge clk_i) disable iff (rst_i)
      (st_reg.seq == S_IDLE & sets_dbg_en_i & st_reg.ctrl[CTL_CMP]) |=> !debug_take_o && !round_take_o;
   endproperty
   a_set_dbg_en: assert property (p_set_dbg_en) else $error("enable-setting instruction reported"); // [RULE10]

   // Turning on the completion enable is not itself reported
   property p_set_cmp;
      @(posedge clk_i) disable iff (rst_i)
      (st_reg.seq == S_IDLE & sets_cmp_i & dbg_on) |=> !debug_take_o && !round_take_o;
   endproperty
   a_set_cmp: assert property (p_set_cmp) else $error("enable-setting instruction reported"); // [RULE11]

   // Flag only drops on a write of one
   property p_sticky;
      @(posedge clk_i) disable iff (rst_i)
      (st_reg.status[ST_CMP] & ~(wr_en & adr_i == OFS_STATUS & dat_i[ST_CMP])) |=> st_reg.status[ST_CMP];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status flag lost"); // [RULE12]

   // Any event term leaves the flag set, even against a clear
   property p_cmp_status;
      @(posedge clk_i) disable iff (rst_i)
      (cmp_evt | round_evt) |=> st_reg.status[ST_CMP];
   endproperty
   a_cmp_status: assert property (p_cmp_status) else $error("completion flag not set"); // [RULE4] [RULE12]

   // Imprecise flag rises only through the round case
   property p_imp_round;
      @(posedge clk_i) disable iff (rst_i)
      (~st_reg.status[ST_IMP] & ~round_evt) |=> !st_reg.status[ST_IMP];
   endproperty
   a_imp_round: assert property (p_imp_round) else $error("imprecise flag set without round case"); // [RULE6]

   // No finished instruction, no interrupt launched
   property p_no_done;
      @(posedge clk_i) disable iff (rst_i)
      (st_reg.seq == S_IDLE & ~done_i) |=> !debug_take_o && !round_take_o;
   endproperty
   a_no_done: assert property (p_no_done) else $error("take without completed instruction"); // [RULE1]

   // Round interrupt is a single pulse
   property p_round_once;
      @(posedge clk_i) disable iff (rst_i)
      round_take_o |=> !round_take_o;
   endproperty
   a_round_once: assert property (p_round_once) else $error("round take longer than one cycle"); // [RULE7]

   // Debug address moves only with a finished instruction
   property p_dsra_hold;
      @(posedge clk_i) disable iff (rst_i)
      ~done_i |=> $stable(dsra_o);
   endproperty
   a_dsra_hold: assert property (p_dsra_hold) else $error("debug address changed without event"); // [RULE4]

   // Ordinary save address moves only in the round case
   property p_sra_hold;
      @(posedge clk_i) disable iff (rst_i)
      ~round_evt |=> $stable(sra_o);
   endproperty
   a_sra_hold: assert property (p_sra_hold) else $error("save address changed without round case"); // [RULE7]

endmodule : cmpl_event

// File: sim/completion_event_bit_event_tb_top.sv
// Self-checking bench for the completion debug event unit
module cmpl_event_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import cmpl_pkg::*;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;        // Bus
   logic [4:0]  adr_i;                                          // Byte address
   logic [3:0]  sel_i;                                          // Lanes
   logic [31:0] dat_i, dat_o, sra_o, dsra_o, rd;                // Bus data
   logic [31:0] next_addr_i, round_vec_i, na, rv;               // Addresses
   logic        done_i, suppressed_i, syscall_i, dbg_en_i;      // Core side
   logic        sets_dbg_en_i, sets_cmp_i, round_exc_i;         // Core side
   logic        round_take_o, debug_take_o, irq_o;              // Takes
   logic [15:0] dbg_cnt, rnd_cnt;                               // Handler counts
   logic [2:0]  ctl;                                            // Control copy
   logic [1:0]  st;                                             // Status copy
   logic [31:0] seed;                                           // Random state
   int          errors, comparisons, ntake;                     // Tallies
   cmpl_event #(.AW(32)) u_cmpl_event (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
      .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .done_i, .suppressed_i, .syscall_i,
      .dbg_en_i, .sets_dbg_en_i, .sets_cmp_i, .round_exc_i, .next_addr_i, .round_vec_i,
      .round_take_o, .debug_take_o, .sra_o, .dsra_o, .irq_o);
   cmpl_handler u_cmpl_handler (.clk_i, .rst_i, .round_take_i(round_take_o),
      .debug_take_i(debug_take_o), .dbg_cnt_o(dbg_cnt), .rnd_cnt_o(rnd_cnt));
   // Xorshift step
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Precise take expected for these core inputs
   function automatic logic want(input logic [2:0] c, input logic p, s, d, sd, se);
      return c[0] & (d | c[1]) & (!p | s) & !(sd & c[0]) & !(se & (d | c[1]));
   endfunction : want
   // Verdict and end of run
   task summarize();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   // Compare seen against expected
   task chk(input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Classic single cycle; bounded wait on ack
   task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge clk_i);
      end
      if (ack_o !== 1'b1)
      begin
         errors++;
         summarize();
      end
      else
      begin
         rd = dat_o;
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
      end
   endtask : wb
   // One completed instruction, then check the takes
   task ev(input logic p, s, d, sd, se, r);
      logic t;
      t = !r & want(ctl, p, s, d, sd, se);
      na = xs(seed);
      rv = xs(na);
      seed = rv;
      @(posedge clk_i);
      done_i <= 1'b1;
      {suppressed_i, syscall_i, dbg_en_i, sets_dbg_en_i, sets_cmp_i, round_exc_i} <= {p, s, d, sd, se, r};
      next_addr_i <= na;
      round_vec_i <= rv;
      @(posedge clk_i);
      {done_i, sets_cmp_i, round_exc_i} <= 3'h0;
      #1;
      chk(debug_take_o, t);
      if (t)
         chk(dsra_o, na);
      st[0] = st[0] | t | r;
      st[1] = st[1] | r;
      ntake += int'(t | r);
      if (se)
         ctl[0] = 1'b1;
      if (r)
      begin
         chk(round_take_o, 1'b1);
         chk(sra_o, na);
         chk(dsra_o, rv);
         @(posedge clk_i);
         #1;
         chk(debug_take_o, 1'b1);
      end
   endtask : ev
   // Free-running core clock
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Main sequence
   initial
   begin
      {cyc_i, stb_i, we_i, done_i, suppressed_i, syscall_i, dbg_en_i} = 7'h00;
      {sets_dbg_en_i, sets_cmp_i, round_exc_i, adr_i} = 8'h00;
      {dat_i, next_addr_i, round_vec_i} = '0;
      sel_i = 4'hf;
      rst_i = 1'b1;
      {errors, comparisons, ntake} = 0;
      {ctl, st} = 5'h00;
      seed = 32'h355a3f7a;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, {29'h0, CTRL_RST});
      wb(1'b0, 5'h14, 32'h0);
      chk(rd, 32'h0); // Unmapped reads zero
      // Hand-written corner cases
      wb(1'b1, OFS_CTRL, 32'h1);
      ctl = 3'h1;
      ev(0, 0, 0, 0, 0, 0);
      ev(0, 0, 1, 0, 0, 0);
      ev(1, 0, 1, 0, 0, 0);
      ev(1, 1, 1, 0, 0, 0);
      ev(0, 0, 1, 1, 0, 0);
      ev(0, 0, 1, 0, 1, 0);
      // Sticky flag and masked interrupt level
      wb(1'b1, OFS_MASK, 32'h1);
      #1 chk(irq_o, 1'b1); // Unmasked status drives irq
      wb(1'b0, OFS_MASK, 32'h0);
      chk(rd, 32'h1); // Mask reads back
      repeat (5) @(posedge clk_i);
      wb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, {30'h0, st});
      wb(1'b1, OFS_STATUS, 32'h1);
      st = 2'h0;
      #1 chk(irq_o, 1'b0); // Cleared flag drops irq
      // Random traffic, control rewritten now and then
      repeat (200)
      begin
         seed = xs(seed);
         if (seed[7:5] == 3'h0)
         begin
            ctl = seed[10:8];
            wb(1'b1, OFS_CTRL, {29'h0, ctl});
         end
         ev(seed[0], seed[1], seed[2], seed[3], seed[4] & seed[11], 1'b0);
      end
      wb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, {30'h0, st});
      // Round case, internal then external mode
      for (int k = 0; k < 2; k++)
      begin
         wb(1'b1, OFS_STATUS, 32'h3);
         st = 2'h0;
         ctl = k ? 3'h3 : 3'h5;
         wb(1'b1, OFS_CTRL, {29'h0, ctl});
         ev(0, 0, 0, 0, 0, 1);
         wb(1'b0, OFS_STATUS, 32'h0);
         chk(rd, 32'h3);
         wb(1'b0, OFS_SRA, 32'h0);
         chk(rd, na);
         wb(1'b0, OFS_DSRA, 32'h0);
         chk(rd, rv);
      end
      chk(dbg_cnt, ntake[15:0]);
      chk(rnd_cnt, 16'h0002);
      summarize();
   end
endmodule : cmpl_event_tb_top

// File: sim/completion_event_bit_handler.sv
// Debug handler model: counts interrupts taken by the core
module cmpl_handler (
   // Clock and reset
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   // Takes from the unit
   input  wire logic   round_take_i,
   input  wire logic   debug_take_i,
   // Handler entry counts
   output logic [15:0] dbg_cnt_o,
   output logic [15:0] rnd_cnt_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // One handler run per pulse; a stuck pulse shows as overcount
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dbg_cnt_o <= 16'h0000;
         rnd_cnt_o <= 16'h0000;
      end
      else
      begin
         dbg_cnt_o <= dbg_cnt_o + {15'h0000, debug_take_i};
         rnd_cnt_o <= rnd_cnt_o + {15'h0000, round_take_i};
      end
   end
endmodule : cmpl_handler
